// >>> hdl/audio_eq_coefficient_loader.sv
// equalizer mode, surround settings and coefficient load control
// assumes one 40 MHz clock shared with the AXI4-Lite master and the core
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01: the two-bit mode selects off, parametric, tone control or graphic.
// R02: parametric filtering runs only in mode 1 with a nonzero count.
// R03: surround width runs 0 least to 7 most and resets to 4.
// R04: surround select codes 0 and 1 are off, 2 mono, 3 stereo.
// R05: writing one to bit 8 of the access register loads the band.
// R06: the 8-bit index picks bands 0 to 4 with codes 0-4, last band with 6.
// R07: each band takes five 20-bit coefficients from register pairs.
// R08: the host writes coefficients first, then index, then load.
// R09: index and load may arrive in one write and that index is used.
// R10: the b0 upper register is write-only and holds bits 19 to 4.
// R11: each lower register holds bits 3 to 0, upper bits reserved.
// R12: the filter count enables that many cascaded filters, 0 is off.
// R13: the load bit is a pulse, reads zero, and data stay after a load.
module audio_eq_coefficient_loader (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output audio_eq_pkg::dsp_cfg_s dsp_cfg,
	output audio_eq_pkg::coef_load_s coef_load
);

	audio_eq_pkg::state_s s_q;
	audio_eq_pkg::state_s s_d;
	logic wr_fire;
	logic [9:0] ar_idx;

	// byte-lane merge, used for every writable register except the lower coefficient halves
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] strb);
		merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
			strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// true when an index maps to any register
	function automatic logic mapped(input logic [9:0] idx);
		logic hit;
		hit = (idx == audio_eq_pkg::IDX_PCNT) || (idx == audio_eq_pkg::IDX_EQ)
			|| (idx == audio_eq_pkg::IDX_SUR) || (idx == audio_eq_pkg::IDX_ACC);
		for (int i = 0; i < audio_eq_pkg::NCOEF; i++) begin
			hit = hit || (idx == audio_eq_pkg::IDX_UP[i])
				|| (idx == audio_eq_pkg::IDX_LO[i]);
		end
		mapped = hit;
	endfunction

	// R06 band code check
	function automatic logic band_ok(input logic [7:0] idx);
		band_ok = (idx <= audio_eq_pkg::BAND_MAX)
			|| (idx == audio_eq_pkg::BAND_LAST);
	endfunction

	// handshakes stay combinational; one write and one read at a time
	assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = {16'h0000, s_q.rdata};
	assign dsp_cfg = s_q.cfg;
	assign coef_load = s_q.ld;
	assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
	assign ar_idx = s_axi_araddr[11:2];

	// next state: bus capture, register writes, readback, load pulse
	always_comb begin
		logic [15:0] wv;
		logic [7:0] acc_idx;
		wv = 16'h0000;
		acc_idx = 8'h00;
		s_d = s_q;
		// R13 load is a single-cycle strobe
		s_d.ld.load = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_held = 1'b1;
			s_d.aw_idx = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata[15:0];
			s_d.wstrb = s_axi_wstrb[1:0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// address and data may arrive in either order; act once both held
		if (wr_fire) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = mapped(s_q.aw_idx) ? audio_eq_pkg::RESP_OKAY
				: audio_eq_pkg::RESP_SLVERR;
			case (s_q.aw_idx)
				audio_eq_pkg::IDX_EQ: begin
					wv = merge16({14'h0000, s_q.cfg.eq_mode}, s_q.wdata,
						s_q.wstrb);
					s_d.cfg.eq_mode = wv[audio_eq_pkg::EQ_MODE_LSB +: 2];
				end
				audio_eq_pkg::IDX_PCNT: begin
					wv = merge16({13'h0000, s_q.cfg.par_count}, s_q.wdata,
						s_q.wstrb);
					s_d.cfg.par_count = wv[audio_eq_pkg::PCNT_LSB +: 3];
				end
				audio_eq_pkg::IDX_SUR: begin
					wv = merge16({9'h000, s_q.cfg.sur_width, 2'h0,
						s_q.cfg.sur_sel}, s_q.wdata, s_q.wstrb);
					// R03 width code stored as written
					s_d.cfg.sur_width = wv[audio_eq_pkg::SUR_WIDTH_LSB +: 3];
					s_d.cfg.sur_sel = wv[audio_eq_pkg::SUR_SEL_LSB +: 2];
				end
				audio_eq_pkg::IDX_ACC: begin
					wv = merge16({8'h00, s_q.band_idx}, s_q.wdata, s_q.wstrb);
					// R09 index of this same write drives the load
					acc_idx = wv[audio_eq_pkg::ACC_IDX_LSB +: 8];
					s_d.band_idx = acc_idx;
					// R05 load strobe with a valid band
					if (s_q.wstrb[1] && s_q.wdata[audio_eq_pkg::ACC_LOAD_BIT]
						&& band_ok(acc_idx)) begin
						s_d.ld.load = 1'b1;
						s_d.ld.band = acc_idx[2:0];
						// R07 five 20-bit coefficients assembled
						for (int i = 0; i < audio_eq_pkg::NCOEF; i++) begin
							s_d.ld.values[i] = {s_q.up[i], s_q.lo[i]};
						end
					end
				end
				default: begin
					// R10 R11 write-only coefficient halves
					for (int i = 0; i < audio_eq_pkg::NCOEF; i++) begin
						if (s_q.aw_idx == audio_eq_pkg::IDX_UP[i]) begin
							s_d.up[i] = merge16(s_q.up[i], s_q.wdata,
								s_q.wstrb);
						end
						if (s_q.aw_idx == audio_eq_pkg::IDX_LO[i]
							&& s_q.wstrb[0]) begin
							s_d.lo[i] = s_q.wdata[audio_eq_pkg::LO_W-1:0];
						end
					end
				end
			endcase
		end
		// R01 R02 R12 decoded enables follow the stored fields
		s_d.cfg.parametric_on = (s_d.cfg.eq_mode == audio_eq_pkg::EQ_PAR)
			&& (s_d.cfg.par_count != 3'h0);
		s_d.cfg.tone_on = (s_d.cfg.eq_mode == audio_eq_pkg::EQ_TONE);
		s_d.cfg.graphic_on = (s_d.cfg.eq_mode == audio_eq_pkg::EQ_GRAPH);
		// R04 codes 0 and 1 both leave the effect off
		s_d.cfg.sur_mono = (s_d.cfg.sur_sel == audio_eq_pkg::SUR_MONO);
		s_d.cfg.sur_stereo = (s_d.cfg.sur_sel == audio_eq_pkg::SUR_STEREO);
		// reads: write-only fields and load bit return zero
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = mapped(ar_idx) ? audio_eq_pkg::RESP_OKAY
				: audio_eq_pkg::RESP_SLVERR;
			case (ar_idx)
				audio_eq_pkg::IDX_EQ: s_d.rdata = {14'h0000, s_q.cfg.eq_mode};
				audio_eq_pkg::IDX_PCNT: s_d.rdata = {13'h0000, s_q.cfg.par_count};
				audio_eq_pkg::IDX_SUR: s_d.rdata = {9'h000, s_q.cfg.sur_width,
					2'h0, s_q.cfg.sur_sel};
				// R13 load bit never reads back
				audio_eq_pkg::IDX_ACC: s_d.rdata = {8'h00, s_q.band_idx};
				default: s_d.rdata = 16'h0000;
			endcase
		end
	end

	// single register stage; reset loads documented defaults
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.cfg.eq_mode <= audio_eq_pkg::EQ_MODE_RST;
			s_q.cfg.par_count <= audio_eq_pkg::PCNT_RST;
			s_q.cfg.sur_width <= audio_eq_pkg::SUR_WIDTH_RST;
			s_q.cfg.sur_sel <= audio_eq_pkg::SUR_SEL_RST;
			s_q.band_idx <= audio_eq_pkg::ACC_IDX_RST;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_mode_decode;
		dsp_cfg.graphic_on == (dsp_cfg.eq_mode == 2'h3)
			&& dsp_cfg.tone_on == (dsp_cfg.eq_mode == 2'h2);
	endproperty
	a_mode_decode: assert property (p_mode_decode) // R01
		else $error("mode decode wrong");

	property p_par_gate;
		dsp_cfg.parametric_on == (dsp_cfg.eq_mode == 2'h1
			&& dsp_cfg.par_count != 3'h0);
	endproperty
	a_par_gate: assert property (p_par_gate) // R02
		else $error("parametric enable wrong");

	property p_width_write;
		wr_fire && s_q.aw_idx == 10'h10a && s_q.wstrb[0]
			|=> dsp_cfg.sur_width == $past(s_q.wdata[6:4]);
	endproperty
	a_width_write: assert property (p_width_write) // R03
		else $error("width not stored");

	property p_sur_decode;
		(dsp_cfg.sur_mono || dsp_cfg.sur_stereo) == dsp_cfg.sur_sel[1]
			&& !(dsp_cfg.sur_mono && dsp_cfg.sur_stereo);
	endproperty
	a_sur_decode: assert property (p_sur_decode) // R04
		else $error("surround decode wrong");

	property p_load_fire;
		wr_fire && s_q.aw_idx == 10'h10c && s_q.wstrb == 2'h3
			&& s_q.wdata[8] && s_q.wdata[7:0] == 8'h06 |=> coef_load.load
			&& coef_load.band == 3'h6;
	endproperty
	a_load_fire: assert property (p_load_fire) // R05
		else $error("load missed");

	property p_bad_band;
		wr_fire && s_q.aw_idx == 10'h10c && s_q.wstrb == 2'h3
			&& s_q.wdata[7:0] == 8'h05 |=> !coef_load.load;
	endproperty
	a_bad_band: assert property (p_bad_band) // R06
		else $error("load on unused code");

	property p_same_index;
		coef_load.load |-> coef_load.band == s_q.band_idx[2:0];
	endproperty
	a_same_index: assert property (p_same_index) // R09
		else $error("load used stale index");

	property p_pulse;
		coef_load.load |=> !coef_load.load;
	endproperty
	a_pulse: assert property (p_pulse) // R13
		else $error("load longer than one cycle");

	property p_b0_split;
		coef_load.load |-> coef_load.values[0] == {s_q.up[0], s_q.lo[0]};
	endproperty
	a_b0_split: assert property (p_b0_split) // R10
		else $error("b0 halves misplaced");

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) // write response held until accepted
		else $error("bvalid dropped early");

	property p_lo_write;
		wr_fire && s_q.aw_idx == audio_eq_pkg::IDX_LO[0] && s_q.wstrb[0]
			|=> s_q.lo[0] == $past(s_q.wdata[3:0]);
	endproperty
	a_lo_write: assert property (p_lo_write) // R11
		else $error("b0 lower bits not stored");

	// a load bit in a disabled lane must not fire a load
	property p_lane_gate;
		wr_fire && s_q.aw_idx == audio_eq_pkg::IDX_ACC && !s_q.wstrb[1]
			|=> !coef_load.load;
	endproperty
	a_lane_gate: assert property (p_lane_gate) // R05
		else $error("load from disabled lane");

	property p_last_pair;
		coef_load.load |-> coef_load.values[4] == {s_q.up[4], s_q.lo[4]};
	endproperty
	a_last_pair: assert property (p_last_pair) // R07
		else $error("a2 halves misplaced");

	// nothing above bit 7 ever reads back, the load bit included
	property p_read_high;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_read_high: assert property (p_read_high) // R13
		else $error("upper read bits not zero");

	c_load: cover property (coef_load.load);
	c_stereo: cover property (dsp_cfg.sur_stereo);
	c_par: cover property (dsp_cfg.parametric_on);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_mono: cover property (dsp_cfg.sur_mono);

endmodule

`default_nettype wire

// >>> hdl/audio_eq_pkg.sv
// constants and carrier types for the equalizer coefficient loader
// assumes a 32-bit AXI4-Lite master; registers are 16 bits in the low half
`default_nettype none
package audio_eq_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_PCNT = 10'h102;
	localparam logic [9:0] IDX_EQ = 10'h108;
	localparam logic [9:0] IDX_SUR = 10'h10a;
	localparam logic [9:0] IDX_ACC = 10'h10c;
	// coefficient pairs in the order b0, b1, b2, a1, a2
	localparam logic [9:0] IDX_UP [5] = '{10'h10e, 10'h140, 10'h142,
		10'h144, 10'h146};
	localparam logic [9:0] IDX_LO [5] = '{10'h110, 10'h141, 10'h143,
		10'h145, 10'h147};

	localparam int NCOEF = 5;
	localparam int CW = 20;
	localparam int LO_W = 4;

	// field positions
	localparam int EQ_MODE_LSB = 0;
	localparam int PCNT_LSB = 0;
	localparam int SUR_WIDTH_LSB = 4;
	localparam int SUR_SEL_LSB = 0;
	localparam int ACC_IDX_LSB = 0;
	localparam int ACC_LOAD_BIT = 8;

	// reset values
	localparam logic [1:0] EQ_MODE_RST = 2'h0;
	localparam logic [2:0] PCNT_RST = 3'h0;
	localparam logic [2:0] SUR_WIDTH_RST = 3'h4;
	localparam logic [1:0] SUR_SEL_RST = 2'h0;
	localparam logic [7:0] ACC_IDX_RST = 8'h00;

	// codes
	localparam logic [1:0] EQ_OFF = 2'h0;
	localparam logic [1:0] EQ_PAR = 2'h1;
	localparam logic [1:0] EQ_TONE = 2'h2;
	localparam logic [1:0] EQ_GRAPH = 2'h3;
	localparam logic [1:0] SUR_MONO = 2'h2;
	localparam logic [1:0] SUR_STEREO = 2'h3;
	localparam logic [7:0] BAND_MAX = 8'h04;
	localparam logic [7:0] BAND_LAST = 8'h06;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] eq_mode;
		logic parametric_on;
		logic tone_on;
		logic graphic_on;
		logic [2:0] par_count;
		logic [2:0] sur_width;
		logic [1:0] sur_sel;
		logic sur_mono;
		logic sur_stereo;
	} dsp_cfg_s;

	typedef struct packed {
		logic load;
		logic [2:0] band;
		logic [NCOEF-1:0][CW-1:0] values;
	} coef_load_s;

	typedef struct packed {
		logic aw_held;
		logic [9:0] aw_idx;
		logic w_held;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
		logic [7:0] band_idx;
		logic [NCOEF-1:0][15:0] up;
		logic [NCOEF-1:0][LO_W-1:0] lo;
		dsp_cfg_s cfg;
		coef_load_s ld;
	} state_s;

endpackage

`default_nettype wire

// >>> testbench/host_axi_model.sv
// host side of the register bus: one write and one read at a time
// assumes its tasks are called from the bench right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_axi_model (
	input wire logic ref_clk,
	output logic [15:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [15:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// response code of the last read, for the bench to compare
	logic [1:0] rresp_seen;

	// bus idle at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
		s_axi_rready = 1'b0;
	end

	// write: address and data raised together, each dropped once taken
	// ready is looked at mid-cycle, so the transfer edge is known in advance
	task automatic wr(input logic [9:0] ix, input logic [15:0] d,
		input logic [3:0] st, output logic [1:0] resp);
		logic ta, tw, pa, pw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= {4'h0, ix, 2'h0};
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge ref_clk);
			pa = !ta && s_axi_awready;
			pw = !tw && s_axi_wready;
			@(posedge ref_clk);
			// released lines do not keep their old value
			if (pa) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~s_axi_awaddr;
				ta = 1'b1;
			end
			if (pw) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~s_axi_wdata;
				tw = 1'b1;
			end
		end
		do @(negedge ref_clk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask

	// read: address held until taken, data taken at the rready edge
	task automatic rd(input logic [9:0] ix, output logic [31:0] d);
		@(posedge ref_clk);
		s_axi_araddr <= {4'h0, ix, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge ref_clk); while (!s_axi_arready);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~s_axi_araddr;
		do @(negedge ref_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rresp_seen = s_axi_rresp;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench/test_audio_eq_coefficient_loader.sv
// self-checking bench for the coefficient loader
// assumes the host model drives every register access
`timescale 1ns/1ps
`default_nettype none
module test_audio_eq_coefficient_loader;
	logic ref_clk, rst_n;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	audio_eq_pkg::dsp_cfg_s dsp_cfg;
	audio_eq_pkg::coef_load_s coef_load, seen;
	int miscompares = 0, cmp_count = 0, loads = 0;
	typedef struct packed {
		logic [9:0] ix;
		logic [15:0] d;
		logic [15:0] rd;
		logic [1:0] resp;
	} row_s;
	row_s rows [7] = '{
		'{audio_eq_pkg::IDX_EQ, 16'hfff1, 16'h0001, 2'h0},
		'{audio_eq_pkg::IDX_SUR, 16'hffff, 16'h0073, 2'h0},
		'{audio_eq_pkg::IDX_PCNT, 16'h000f, 16'h0007, 2'h0},
		'{audio_eq_pkg::IDX_ACC, 16'h0005, 16'h0005, 2'h0},
		'{audio_eq_pkg::IDX_UP[0], 16'habcd, 16'h0000, 2'h0},
		'{audio_eq_pkg::IDX_LO[0], 16'h00f5, 16'h0000, 2'h0},
		'{10'h3ff, 16'h1234, 16'h0000, 2'h2}};
	logic [7:0] bands [3] = '{8'h06, 8'h02, 8'h05};

	audio_eq_coefficient_loader i_audio_eq_coefficient_loader (.ref_clk,
		.rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dsp_cfg, .coef_load);
	host_axi_model i_host_axi_model (.ref_clk, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// count load pulses mid-cycle; a long pulse counts twice
	always @(negedge ref_clk) begin
		if (coef_load.load) begin
			loads++;
			seen = coef_load;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#100us;
		miscompares++;
		print_verdict();
	end

	// main sequence
	initial begin
		logic [31:0] r;
		logic [1:0] b;
		int n, j;
		rst_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		// ordinary cases: write, response, read back
		foreach (rows[i]) begin
			i_host_axi_model.wr(rows[i].ix, rows[i].d, 4'hf, b);
			chk(b, rows[i].resp);
			i_host_axi_model.rd(rows[i].ix, r);
			chk(r, rows[i].rd);
			chk(i_host_axi_model.rresp_seen, rows[i].resp);
		end
		chk(loads, 0);
		// every mode, with the filter count off then at its maximum
		for (n = 0; n < 8; n++) begin
			i_host_axi_model.wr(audio_eq_pkg::IDX_PCNT, {13'h0, {3{n[2]}}},
				4'hf, b);
			i_host_axi_model.wr(audio_eq_pkg::IDX_EQ, {14'h0, n[1:0]}, 4'hf, b);
			chk({dsp_cfg.eq_mode, dsp_cfg.par_count, dsp_cfg.parametric_on,
				dsp_cfg.tone_on, dsp_cfg.graphic_on}, {n[1:0], {3{n[2]}},
				n == 5, n[1:0] == 2'h2, n[1:0] == 2'h3});
		end
		// every surround select, width codes 4 to 7
		for (n = 0; n < 4; n++) begin
			i_host_axi_model.wr(audio_eq_pkg::IDX_SUR,
				{9'h0, 1'b1, n[1:0], 2'h0, n[1:0]}, 4'hf, b);
			chk({dsp_cfg.sur_width, dsp_cfg.sur_sel, dsp_cfg.sur_mono,
				dsp_cfg.sur_stereo}, {1'b1, n[1:0], n[1:0], n == 2,
				n == 3});
		end
		// coefficients come first
		// reserved lower bits set on purpose
		for (n = 0; n < 5; n++) begin
			i_host_axi_model.wr(audio_eq_pkg::IDX_UP[n], {4{4'(n + 9)}},
				4'hf, b);
			i_host_axi_model.wr(audio_eq_pkg::IDX_LO[n], {12'hfff, 4'(n + 1)},
				4'hf, b);
		end
		// index and load together; second load reuses the same data
		foreach (bands[k]) begin
			i_host_axi_model.wr(audio_eq_pkg::IDX_ACC, {8'h01, bands[k]},
				4'hf, b);
			chk(loads, (k < 2) ? k + 1 : 2);
			chk(seen.band, bands[k < 2 ? k : 1][2:0]);
			for (j = 0; j < 5; j++)
				chk(seen.values[j], {{4{4'(j + 9)}}, 4'(j + 1)});
			i_host_axi_model.rd(audio_eq_pkg::IDX_ACC, r);
			chk(r, {24'h0, bands[k]});
		end
		// load bit with its lane disabled: index lane still lands
		i_host_axi_model.wr(audio_eq_pkg::IDX_ACC, 16'h0103, 4'h1, b);
		chk(loads, 2);
		i_host_axi_model.rd(audio_eq_pkg::IDX_ACC, r);
		chk(r, 32'h3);
		// second reset in mid-run
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		chk(dsp_cfg.sur_width, 3'h4);
		chk(dsp_cfg, {8'h00, audio_eq_pkg::SUR_WIDTH_RST, 4'h0});
		i_host_axi_model.rd(audio_eq_pkg::IDX_SUR, r);
		chk(r, 32'h40);
		i_host_axi_model.rd(audio_eq_pkg::IDX_ACC, r);
		chk(r, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
